// ==== ardh_cfg.svh ====
`ifndef ARDH_CFG_SVH
`define ARDH_CFG_SVH

// register offsets on the plain register port
`define ARDH_OFS_DATA       3'h0
`define ARDH_OFS_ERROR      3'h1
`define ARDH_OFS_SEC_COUNT  3'h2
`define ARDH_OFS_SEC_NUM    3'h3
`define ARDH_OFS_CYL_LOW    3'h4
`define ARDH_OFS_CYL_HIGH   3'h5
`define ARDH_OFS_DRV_HEAD   3'h6
`define ARDH_OFS_CMD        3'h7

// opcodes
`define ARDH_OPC_READ_DMA   8'hc8
`define ARDH_OPC_RBUF_DMA   8'he9
`define ARDH_OPC_WBUF       8'he8

// drive_condition bit positions
`define ARDH_COND_BUSY      7
`define ARDH_COND_READY     6
`define ARDH_COND_FAULT     5
`define ARDH_COND_SEEK      4
`define ARDH_COND_DRQ       3
`define ARDH_COND_CORR      2
`define ARDH_COND_INDEX     1
`define ARDH_COND_ERR       0

// error_flags bit positions
`define ARDH_ERR_UNCORR     6
`define ARDH_ERR_IDNF       4
`define ARDH_ERR_ABORT      2

// drive_select_head address-mode bit
`define ARDH_DH_LBA         6

// reset values
`define ARDH_COND_RESET     8'h50
`define ARDH_ERR_RESET      8'h00
`define ARDH_SC_RESET       8'h01
`define ARDH_SN_RESET       8'h01

// sector geometry in 16-bit words
`define ARDH_SECTOR_WORDS   256
`define ARDH_WIDX_W         8

`endif

// ==== ardh_media_model.sv ====
`timescale 1ns/100ps

module ardh_media_model (
  input  wire logic        clock_in,
  input  wire logic        start_in,
  input  wire logic [27:0] addr_in,
  input  wire logic [27:0] fail_addr_in,
  output logic             valid_out,
  output logic      [15:0] word_out,
  output logic             done_out,
  output logic             uncorr_out
);
  logic [27:0] sect;

  initial begin
    valid_out = 1'b0;
    word_out  = 16'hffff;
    done_out  = 1'b0;
    uncorr_out = 1'b0;
  end

  // one sector per start; idle word is inverted so it never looks valid
  always begin
    @(posedge clock_in);
    if (start_in === 1'b1) begin
      sect = addr_in;
      repeat (3) @(posedge clock_in);
      for (int i = 0; i < 256; i++) begin
        valid_out <= 1'b1;
        word_out  <= {sect[7:0], 8'(i)};
        @(posedge clock_in);
      end
      valid_out <= 1'b0;
      word_out  <= ~word_out;
      done_out  <= 1'b1;
      uncorr_out <= (sect == fail_addr_in);
      @(posedge clock_in);
      done_out   <= 1'b0;
      uncorr_out <= 1'b0;
    end
  end
endmodule : ardh_media_model

// ==== ardh_pkg.sv ====
`include "ardh_cfg.svh"

package ardh_pkg;

  // command sequencer states
  typedef enum logic [2:0] {
    ARDH_IDLE,
    ARDH_WBUF,
    ARDH_MSTART,
    ARDH_MFILL,
    ARDH_XFER
  } ardh_state_e;

  // media-side sector stream
  typedef struct packed {
    logic        word_valid;
    logic [15:0] word;
    logic        sector_done;
    logic        uncorr;
  } ardh_media_s;

  // whole state of the command handler
  typedef struct packed {
    ardh_state_e                              state;
    logic [7:0]                               sec_count;
    logic [7:0]                               sec_num;
    logic [7:0]                               cyl_low;
    logic [7:0]                               cyl_high;
    logic [7:0]                               drv_head;
    logic [7:0]                               err_flags;
    logic [7:0]                               cond;
    logic                                     lba_mode;
    logic                                     media_cmd;
    logic                                     intrq;
    logic                                     dreq;
    logic                                     mstart;
    logic [15:0]                              rdata;
    logic [15:0]                              ddata;
    logic [`ARDH_WIDX_W-1:0]                  widx;
    logic [8:0]                               remain;
    logic [`ARDH_SECTOR_WORDS-1:0][15:0]      sbuf;
  } ardh_state_s;

endpackage : ardh_pkg

// ==== ardh_read_dma.sv ====
// Operation
// - buffer-read DMA sends exactly one sector
// - data comes from last buffer-write region
// - media reads may overwrite that buffer
// - data moves one 16-bit word each
// - media-read DMA reads sectors then delivers
// - lowest opcode bit ignored, retry selector
// - each word qualified by DMA request
// - one interrupt after transfer, status valid
// - uncorrectable error stops at failing sector
// - sector count zero means 256
// - CHS: sector number and cylinder start
// - CHS: head bits select first head
// - LBA: sector number is bits 0-7
// - LBA: cylinder low/high bits 8-23
// - LBA: head bits are bits 24-27
// - sector count returns sectors not transferred
// - CHS: registers report last transferred sector; after an uncorrectable error they hold the failing sector
// - LBA: registers hold current block address
`timescale 1ns/100ps
`include "ardh_cfg.svh"

module ardh_read_dma #(
  parameter int         SECTOR_WORDS      = `ARDH_SECTOR_WORDS,
  parameter logic [7:0] SECTORS_PER_TRACK = 8'h3f,
  parameter logic [3:0] LAST_HEAD         = 4'hf
) (
  input  wire logic        clock_in,
  input  wire logic        rst_b_in,
  input  wire logic [2:0]  addr_in,
  input  wire logic [15:0] wdata_in,
  input  wire logic        wr_in,
  input  wire logic        rd_in,
  output logic      [15:0] rdata_out,
  output logic             dma_req_out,
  input  wire logic        dma_ack_in,
  output logic      [15:0] dma_data_out,
  output logic             intrq_out,
  output logic             media_start_out,
  output logic             media_lba_out,
  output logic      [27:0] media_addr_out,
  input  wire logic        media_word_valid_in,
  input  wire logic [15:0] media_word_in,
  input  wire logic        media_sector_done_in,
  input  wire logic        media_uncorr_in
);

  // structure is fixed by the packed state, so refuse anything else
  if (SECTOR_WORDS != `ARDH_SECTOR_WORDS) begin : g_bad_words
    $error("sector size must match the configured word count");
  end
  if (SECTOR_WORDS > (1 << `ARDH_WIDX_W)) begin : g_bad_index
    $error("word index too narrow for the sector size");
  end
  if (SECTORS_PER_TRACK == 8'h00) begin : g_bad_spt
    $error("sectors per track must be at least one");
  end

  localparam logic [`ARDH_WIDX_W-1:0] LAST_WORD = `ARDH_WIDX_W'(`ARDH_SECTOR_WORDS - 1);
  localparam logic [`ARDH_WIDX_W-1:0] WORD_ONE  = `ARDH_WIDX_W'(1);

  localparam ardh_pkg::ardh_state_s ST_RESET = '{
    state:     ardh_pkg::ARDH_IDLE,
    sec_count: `ARDH_SC_RESET,
    sec_num:   `ARDH_SN_RESET,
    err_flags: `ARDH_ERR_RESET,
    cond:      `ARDH_COND_RESET,
    default:   '0
  };

  ardh_pkg::ardh_state_s st_reg;
  ardh_pkg::ardh_state_s st_next;
  ardh_pkg::ardh_media_s media;

  logic [27:0]             lba_now;
  logic [27:0]             lba_inc;
  logic [15:0]             cyl_inc;
  logic [`ARDH_WIDX_W-1:0] widx_inc;
  logic                    is_idle;

  // media stream gathered into one carrier; one driver for the whole struct
  assign media = '{word_valid:  media_word_valid_in,
                   word:        media_word_in,
                   sector_done: media_sector_done_in,
                   uncorr:      media_uncorr_in};

  // outputs straight from the state register
  assign rdata_out       = st_reg.rdata;
  assign dma_req_out     = st_reg.dreq;
  assign dma_data_out    = st_reg.ddata;
  assign intrq_out       = st_reg.intrq;
  assign media_start_out = st_reg.mstart;
  assign media_lba_out   = st_reg.lba_mode;
  assign media_addr_out  = lba_now;

  // completion status byte; busy and fault always clear here
  function automatic logic [7:0] done_cond(input logic with_err);
    logic [7:0] c;
    c = 8'h00;
    c[`ARDH_COND_READY] = 1'b1;
    c[`ARDH_COND_SEEK]  = 1'b1;
    c[`ARDH_COND_ERR]   = with_err;
    return c;
  endfunction : done_cond

  // busy status while the sequencer owns the registers
  function automatic logic [7:0] busy_cond();
    logic [7:0] c;
    c = 8'h00;
    c[`ARDH_COND_BUSY] = 1'b1;
    c[`ARDH_COND_SEEK] = 1'b1;
    return c;
  endfunction : busy_cond

  always_comb begin
    st_next = st_reg;
    is_idle = (st_reg.state == ardh_pkg::ARDH_IDLE);
    lba_now  = {st_reg.drv_head[3:0], st_reg.cyl_high, st_reg.cyl_low, st_reg.sec_num};
    lba_inc  = lba_now + 28'h0000001;
    cyl_inc  = {st_reg.cyl_high, st_reg.cyl_low} + 16'h0001;
    widx_inc = st_reg.widx + WORD_ONE;

    st_next.mstart = 1'b0;
    st_next.rdata  = 16'h0000;

    // register reads; data answers one cycle later
    if (rd_in) begin
      unique case (addr_in)
        `ARDH_OFS_ERROR:     st_next.rdata = {8'h00, st_reg.err_flags};
        `ARDH_OFS_SEC_COUNT: st_next.rdata = {8'h00, st_reg.sec_count};
        `ARDH_OFS_SEC_NUM:   st_next.rdata = {8'h00, st_reg.sec_num};
        `ARDH_OFS_CYL_LOW:   st_next.rdata = {8'h00, st_reg.cyl_low};
        `ARDH_OFS_CYL_HIGH:  st_next.rdata = {8'h00, st_reg.cyl_high};
        `ARDH_OFS_DRV_HEAD:  st_next.rdata = {8'h00, st_reg.drv_head};
        `ARDH_OFS_CMD:       st_next.rdata = {8'h00, st_reg.cond};
        default:             st_next.rdata = 16'h0000;
      endcase
      // status read acknowledges the interrupt
      if (addr_in == `ARDH_OFS_CMD) begin
        st_next.intrq = 1'b0;
      end
    end

    // task register writes only while idle; a busy device ignores them
    if (wr_in && is_idle) begin
      unique case (addr_in)
        `ARDH_OFS_SEC_COUNT: st_next.sec_count = wdata_in[7:0];
        `ARDH_OFS_SEC_NUM:   st_next.sec_num   = wdata_in[7:0];
        `ARDH_OFS_CYL_LOW:   st_next.cyl_low   = wdata_in[7:0];
        `ARDH_OFS_CYL_HIGH:  st_next.cyl_high  = wdata_in[7:0];
        `ARDH_OFS_DRV_HEAD:  st_next.drv_head  = wdata_in[7:0];
        `ARDH_OFS_CMD: begin
          st_next.intrq     = 1'b0;
          st_next.err_flags = 8'h00;
          st_next.widx      = '0;
          if (wdata_in[7:1] == 7'(`ARDH_OPC_READ_DMA >> 1)) begin
            st_next.media_cmd = 1'b1;
            st_next.lba_mode  = st_reg.drv_head[`ARDH_DH_LBA];
            st_next.remain    = (st_reg.sec_count == 8'h00) ? 9'h100
                                                            : {1'b0, st_reg.sec_count};
            st_next.cond      = busy_cond();
            st_next.state     = ardh_pkg::ARDH_MSTART;
          end else if (wdata_in[7:0] == `ARDH_OPC_RBUF_DMA) begin
            // one sector straight from the buffer
            st_next.media_cmd = 1'b0;
            // buffer as last filled, from word zero
            st_next.ddata     = st_reg.sbuf[0];
            st_next.dreq      = 1'b1;
            st_next.cond      = busy_cond();
            st_next.state     = ardh_pkg::ARDH_XFER;
          end else if (wdata_in[7:0] == `ARDH_OPC_WBUF) begin
            st_next.cond                 = done_cond(1'b0);
            st_next.cond[`ARDH_COND_DRQ] = 1'b1;
            st_next.state                = ardh_pkg::ARDH_WBUF;
          end else begin
            // unknown opcode: abort is the only error raised
            st_next.err_flags[`ARDH_ERR_ABORT] = 1'b1;
            st_next.cond  = done_cond(1'b1);
            st_next.intrq = 1'b1;
          end
        end
        default: ;
      endcase
    end

    unique case (st_reg.state)
      ardh_pkg::ARDH_IDLE: ;

      // buffer fill through the data register
      ardh_pkg::ARDH_WBUF: begin
        if (wr_in && addr_in == `ARDH_OFS_DATA) begin
          st_next.sbuf[st_reg.widx] = wdata_in;
          st_next.widx              = widx_inc;
          if (st_reg.widx == LAST_WORD) begin
            st_next.cond  = done_cond(1'b0);
            st_next.intrq = 1'b1;
            st_next.state = ardh_pkg::ARDH_IDLE;
          end
        end
      end

      ardh_pkg::ARDH_MSTART: begin
        st_next.mstart = 1'b1;
        st_next.widx   = '0;
        st_next.state  = ardh_pkg::ARDH_MFILL;
      end

      // media words land in the shared buffer
      ardh_pkg::ARDH_MFILL: begin
        if (media.word_valid) begin
          st_next.sbuf[st_reg.widx] = media.word;
          st_next.widx              = widx_inc;
        end
        if (media.sector_done) begin
          if (media.uncorr) begin
            st_next.err_flags[`ARDH_ERR_UNCORR] = 1'b1;
            // unsent sectors include the failing one
            st_next.sec_count = st_reg.remain[7:0];
            st_next.cond  = done_cond(1'b1);
            st_next.intrq = 1'b1;
            st_next.state = ardh_pkg::ARDH_IDLE;
          end else begin
            st_next.widx  = '0;
            st_next.ddata = st_next.sbuf[0];
            st_next.dreq  = 1'b1;
            st_next.state = ardh_pkg::ARDH_XFER;
          end
        end
      end

      ardh_pkg::ARDH_XFER: begin
        if (st_reg.dreq && dma_ack_in) begin
          if (st_reg.widx != LAST_WORD) begin
            st_next.widx  = widx_inc;
            st_next.ddata = st_reg.sbuf[widx_inc];
          end else begin
            st_next.dreq = 1'b0;
            if (!st_reg.media_cmd) begin
              st_next.cond  = done_cond(1'b0);
              st_next.intrq = 1'b1;
              st_next.state = ardh_pkg::ARDH_IDLE;
            end else if (st_reg.remain == 9'h001) begin
              st_next.remain    = 9'h000;
              st_next.sec_count = 8'h00;
              // interrupt only after the last word
              st_next.cond  = done_cond(1'b0);
              st_next.intrq = 1'b1;
              st_next.state = ardh_pkg::ARDH_IDLE;
            end else begin
              st_next.remain = st_reg.remain - 9'h001;
              st_next.state  = ardh_pkg::ARDH_MSTART;
              if (st_reg.lba_mode) begin
                st_next.sec_num       = lba_inc[7:0];
                st_next.cyl_low       = lba_inc[15:8];
                st_next.cyl_high      = lba_inc[23:16];
                st_next.drv_head[3:0] = lba_inc[27:24];
              end else if (st_reg.sec_num >= SECTORS_PER_TRACK) begin
                // wrap sector, step head then cylinder
                st_next.sec_num = 8'h01;
                if (st_reg.drv_head[3:0] >= LAST_HEAD) begin
                  st_next.drv_head[3:0] = 4'h0;
                  st_next.cyl_low       = cyl_inc[7:0];
                  st_next.cyl_high      = cyl_inc[15:8];
                end else begin
                  st_next.drv_head[3:0] = st_reg.drv_head[3:0] + 4'h1;
                end
              end else begin
                // next sector on the same track
                st_next.sec_num = st_reg.sec_num + 8'h01;
              end
            end
          end
        end
      end
    endcase
  end

  // single state register; reset loads constants only
  always_ff @(posedge clock_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      st_reg <= ST_RESET;
    end else begin
      st_reg <= st_next;
    end
  end

endmodule : ardh_read_dma

// ==== ardh_read_dma_props.sv ====
`timescale 1ns/100ps

module ardh_read_dma_props (
  input wire logic        clock_in,
  input wire logic        rst_b_in,
  input wire logic [2:0]  addr_in,
  input wire logic [15:0] wdata_in,
  input wire logic        wr_in,
  input wire logic        rd_in,
  input wire logic [15:0] rdata_out,
  input wire logic        dma_req_out,
  input wire logic        dma_ack_in,
  input wire logic [15:0] dma_data_out,
  input wire logic        intrq_out,
  input wire logic        media_start_out
);
  logic [9:0] cnt_reg;
  logic [9:0] cnt_next;

  // acks in the current burst, cleared while no request stands
  always_comb begin
    cnt_next = dma_req_out ? cnt_reg + 10'(dma_ack_in) : 10'h0;
  end

  always_ff @(posedge clock_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      cnt_reg <= 10'h0;
    end else begin
      cnt_reg <= cnt_next;
    end
  end

  default clocking cb @(posedge clock_in); endclocking
  default disable iff (!rst_b_in);

  chk_sector_words: assert property
    ($fell(dma_req_out) |-> cnt_reg == 10'h100) else $error("burst not 256 words");
  chk_word_hold: assert property
    (dma_req_out && !dma_ack_in |=> dma_req_out && $stable(dma_data_out))
    else $error("word dropped before ack");
  chk_fetch_first: assert property
    (dma_req_out |-> !media_start_out) else $error("fetch during transfer");
  chk_start_pulse: assert property
    (media_start_out |=> !media_start_out) else $error("start not one cycle");
  chk_read_start: assert property
    (wr_in && addr_in == 3'h7 && wdata_in[7:1] == 7'h64 && intrq_out |=> ##1 media_start_out)
    else $error("media read not started");
  chk_buf_req: assert property
    (wr_in && addr_in == 3'h7 && wdata_in[7:0] == 8'he9 && intrq_out
     |=> dma_req_out && !media_start_out) else $error("buffer read not started");
  chk_irq_late: assert property
    (dma_req_out |-> !intrq_out) else $error("interrupt during transfer");
  chk_irq_clear: assert property
    (rd_in && addr_in == 3'h7 && intrq_out |=> !intrq_out) else $error("irq not cleared");
  chk_rdata_idle: assert property
    (!rd_in |=> rdata_out == 16'h0) else $error("read data outside slot");
endmodule : ardh_read_dma_props

bind ardh_read_dma ardh_read_dma_props chk_u (.clock_in, .rst_b_in, .addr_in, .wdata_in,
  .wr_in, .rd_in, .rdata_out, .dma_req_out, .dma_ack_in, .dma_data_out, .intrq_out,
  .media_start_out);

// ==== testbench.sv ====
`timescale 1ns/100ps

module testbench;
  logic        clock_in   = 1'b0;
  logic        rst_b_in   = 1'b0;
  logic [2:0]  addr_in    = 3'h0;
  logic [15:0] wdata_in   = 16'h0;
  logic        wr_in      = 1'b0;
  logic        rd_in      = 1'b0;
  logic        dma_ack_in = 1'b0;
  logic [15:0] rdata_out;
  logic        dma_req_out;
  logic [15:0] dma_data_out;
  logic        intrq_out;
  logic        m_start;
  logic        m_lba;
  logic [27:0] m_addr;
  logic        m_valid;
  logic [15:0] m_word;
  logic        m_done;
  logic        m_uncorr;
  int          err_count  = 0;
  int          n_compared = 0;
  int          cycles     = 0;

  ardh_read_dma dut_u (.clock_in, .rst_b_in, .addr_in, .wdata_in, .wr_in, .rd_in,
    .rdata_out, .dma_req_out, .dma_ack_in, .dma_data_out, .intrq_out,
    .media_start_out(m_start), .media_lba_out(m_lba), .media_addr_out(m_addr),
    .media_word_valid_in(m_valid), .media_word_in(m_word),
    .media_sector_done_in(m_done), .media_uncorr_in(m_uncorr));

  ardh_media_model media_u (.clock_in, .start_in(m_start), .addr_in(m_addr),
    .fail_addr_in(28'h1234600), .valid_out(m_valid), .word_out(m_word),
    .done_out(m_done), .uncorr_out(m_uncorr));

  always #25 clock_in = ~clock_in;

  // hang guard, generous against a few thousand cycles of work
  always @(posedge clock_in) begin
    cycles++;
    if (cycles == 20000) begin
      err_count++;
      results();
    end
  end

  task results;
    if (err_count == 0 && n_compared > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : results

  task chk(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      err_count++;
      $display("mismatch at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask : chk

  // an idle edge between strobes keeps each strobe a clean pulse
  task wr(input logic [2:0] a, input logic [15:0] d);
    wr_in <= 1'b1;
    addr_in <= a;
    wdata_in <= d;
    @(posedge clock_in);
    wr_in <= 1'b0;
    @(posedge clock_in);
  endtask : wr

  task rd(input logic [2:0] a, input logic [31:0] exp);
    rd_in <= 1'b1;
    addr_in <= a;
    @(posedge clock_in);
    rd_in <= 1'b0;
    @(posedge clock_in);
    chk(32'(rdata_out), exp);
  endtask : rd

  task wait_irq;
    while (intrq_out !== 1'b1) @(posedge clock_in);
  endtask : wait_irq

  task wait_start;
    while (m_start !== 1'b1) @(posedge clock_in);
  endtask : wait_start

  // host slave channel, started after the command write (a buffer-read request is already up), acks every other cycle
  task drain(input logic [7:0] hi);
    int i;
    i = 0;
    while (i < 256) begin
      @(posedge clock_in);
      if (dma_req_out === 1'b1 && dma_ack_in === 1'b1) begin
        chk(32'(dma_data_out), 32'({hi, 8'(i)}));
        i++;
      end
      dma_ack_in <= (i < 256) ? ~dma_ack_in : 1'b0;
    end
  endtask : drain

  task t_buffer;
    rd(3'h7, 32'h50);
    wr(3'h7, 16'he8);
    for (int i = 0; i < 256; i++) wr(3'h0, {8'h5a, 8'(i)});
    // second pass starts with the interrupt still pending
    repeat (2) begin
      wr(3'h7, 16'he9);
      drain(8'h5a);
      wait_irq();
    end
    rd(3'h1, 32'h00);
    rd(3'h7, 32'h50);
    chk(32'(intrq_out), 32'h0);
  endtask : t_buffer

  task t_chs;
    wr(3'h2, 16'h02);
    wr(3'h3, 16'h05);
    wr(3'h4, 16'h02);
    wr(3'h5, 16'h01);
    wr(3'h6, 16'ha3);
    wr(3'h7, 16'hc9);
    wait_start();
    chk({4'h0, m_addr}, 32'h3010205);
    chk(32'(m_lba), 32'h0);
    drain(8'h05);
    drain(8'h06);
    wait_irq();
    rd(3'h2, 32'h00);
    rd(3'h3, 32'h06);
    rd(3'h4, 32'h02);
  endtask : t_chs

  task t_lba_unc;
    wr(3'h2, 16'h00);
    wr(3'h3, 16'hfe);
    wr(3'h4, 16'h45);
    wr(3'h5, 16'h23);
    wr(3'h6, 16'he1);
    wr(3'h7, 16'hc8);
    wait_start();
    chk({4'h0, m_addr}, 32'h12345fe);
    chk(32'(m_lba), 32'h1);
    drain(8'hfe);
    drain(8'hff);
    wait_irq();
    chk(32'(dma_req_out), 32'h0);
    rd(3'h1, 32'h40);
    rd(3'h7, 32'h51);
    rd(3'h2, 32'hfe);
    rd(3'h3, 32'h00);
    rd(3'h4, 32'h46);
    rd(3'h5, 32'h23);
    rd(3'h6, 32'he1);
    // failing sector's media words now sit in the shared buffer
    wr(3'h7, 16'he9);
    drain(8'h00);
    wait_irq();
    rd(3'h7, 32'h50);
  endtask : t_lba_unc

  task t_bad_op;
    wr(3'h7, 16'h00);
    wait_irq();
    rd(3'h1, 32'h04);
    rd(3'h7, 32'h51);
  endtask : t_bad_op

  initial begin
    repeat (5) @(posedge clock_in);
    rst_b_in <= 1'b1;
    @(posedge clock_in);
    t_buffer();
    t_chs();
    t_lba_unc();
    t_bad_op();
    results();
  end
endmodule : testbench
